// >>> logic/masb_defines.svh
/*
  Offsets, field positions, reset values and codes for the abnormal event status block.
  Assumes it is included by bare name; holds definitions only.
*/
`ifndef MASB_DEFINES_SVH
`define MASB_DEFINES_SVH
`define MASB_OFF_STATUS    12'h028
`define MASB_OFF_IRQ_EN    12'h02c
`define MASB_OFF_IRQ_CLR   12'h030
`define MASB_OFF_EVENTS    12'h034
`define MASB_BIT_AIS       15
`define MASB_BIT_BUSERR    13
`define MASB_BIT_GPT       11
`define MASB_BIT_RXWD      9
`define MASB_BIT_RXSTOP    8
`define MASB_BIT_RXNODESC  7
`define MASB_BIT_RXDONE    6
`define MASB_BIT_TXUF      5
`define MASB_BIT_TXJAB     3
`define MASB_BIT_TXSTOP    1
`define MASB_BEK_LSB       23
`define MASB_BEK_MSB       25
`define MASB_BEK_PARITY    3'h0
`define MASB_BEK_MABORT    3'h1
`define MASB_BEK_TABORT    3'h2
`define MASB_FLAG_MASK     32'h0000_2be0
`define MASB_ABN_MASK      32'h0000_2baa
`define MASB_RESET_STATUS  32'h0000_0000
`define MASB_RESET_BEK     3'h0
`define MASB_TXDESC_UF_BIT 1
`endif

// >>> logic/masb_flag_bank.sv
/*
  Bank of sticky event flags, one per bit of the status word.
  Assumes set and clear vectors are synchronous to i_sys_clk.
*/
`timescale 1ns/10ps
`include "masb_defines.svh"
module masb_flag_bank
  import masb_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic  i_sys_clk,   // System clock.
  input  wire logic  i_resetn,    // Asynchronous reset, active low.
  masb_flag_if.bank  fl           // Set, clear and flag word.
);
  logic [W-1:0] flag_r;
  logic [W-1:0] flag_nxt;

  // Each bit is held until a one is written; a set in the same cycle wins.
  for (genvar g = 0; g < W; g++) begin : g_flag
    always_comb begin
      flag_nxt[g] = fl.set_vec[g] | (flag_r[g] & ~fl.clr_vec[g]); // [R14]
    end
  end

  // Registers only; the reset value is the all-zero word.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_r <= `MASB_RESET_STATUS;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign fl.flags = flag_r;
endmodule

// >>> logic/masb_flag_if.sv
/*
  Carrier between the top and the flag bank: per-bit set and clear vectors
  and the latched flag word.
  Assumes both ends share the system clock.
*/
`timescale 1ns/10ps
interface masb_flag_if #(parameter int W = 32);
  logic [W-1:0] set_vec;
  logic [W-1:0] clr_vec;
  logic [W-1:0] flags;
  modport ctrl (output set_vec, output clr_vec, input flags);
  modport bank (input set_vec, input clr_vec, output flags);
endinterface

// >>> logic/masb_pkg.sv
/*
  Types for the abnormal event status block.
  Assumes nothing beyond the defines header.
*/
package masb_pkg;
  typedef enum logic [1:0] {
    MASB_RX_RUN,
    MASB_RX_SUSP,
    MASB_RX_STOP
  } masb_rx_e;
  typedef enum logic [0:0] {
    MASB_BUS_OK,
    MASB_BUS_HALT
  } masb_bus_e;
  typedef logic [2:0] masb_bek_t;
endpackage

// >>> logic/masb_status.sv
/*
  Abnormal event status bits of the DMA status register with an APB slave,
  interrupt enable and clear registers, bus halt and receive suspend control.
  Assumes the DMA engines present one-cycle event pulses on the system clock.
*/
// Design decisions made here: the placing of the registers and the APB register port.
//Contract
//[R1] Summary bit 15 ORs abnormal flags.
//[R2] Bus fault sets bit 13, records kind.
//[R3] After bus fault, no new master accesses.
//[R4] Only software reset restores bus access.
//[R5] General timer expiry latches bit 11.
//[R6] Receive watchdog expiry latches bit 9.
//[R7] Receive entering stop latches bit 8.
//[R8] Missing descriptor sets bit 7, suspends receive.
//[R9] Software gives descriptor, then polls receive.
//[R10] Recognised frame resumes suspended receive.
//[R11] Finished frame latches bit 6.
//[R12] Transmit FIFO underflow latches bit 5.
//[R13] Underflow suspends transmit, marks descriptor bit.
//[R14] Flags sticky, cleared by writing one.
//[R15] Kind codes parity, master, target abort.
//[R16] Summary drops when sources cleared; reserved zero.
`timescale 1ns/10ps
`include "masb_defines.svh"
module masb_status
  import masb_pkg::*;
(
  input  wire logic        i_sys_clk,        // System clock, 100 MHz.
  input  wire logic        i_resetn,         // Asynchronous reset, active low.
  input  wire logic        i_psel,           // APB select.
  input  wire logic        i_penable,        // APB access phase.
  input  wire logic        i_pwrite,         // APB write.
  input  wire logic [11:0] i_paddr,          // APB byte address.
  input  wire logic [31:0] i_pwdata,         // APB write data.
  output logic             o_pready,         // APB ready.
  output logic [31:0]      o_prdata,         // APB read data.
  output logic             o_pslverr,        // APB error on unmapped address.
  input  wire logic        i_soft_reset,     // Software reset pulse.
  input  wire logic        i_parity_err,     // Bus parity error pulse.
  input  wire logic        i_master_abort,   // Bus master abort pulse.
  input  wire logic        i_target_abort,   // Bus target abort pulse.
  input  wire logic        i_gpt_expired,    // General timer ran out.
  input  wire logic        i_rxwd_expired,   // Receive watchdog timed out.
  input  wire logic        i_rx_to_stop,     // Receive state entered stop.
  input  wire logic        i_rx_desc_miss,   // Next receive descriptor unavailable.
  input  wire logic        i_rx_poll,        // Receive poll demand.
  input  wire logic        i_rx_addr_match,  // New frame passed address filter.
  input  wire logic        i_rx_done,        // Frame reception finished.
  input  wire logic        i_tx_underflow,   // Transmit FIFO ran empty mid frame.
  input  wire logic        i_tx_stopped,     // Transmit stopped event.
  input  wire logic        i_tx_jabber,      // Transmit jabber expiry event.
  input  wire logic        i_tx_resume,      // Transmit poll demand.
  output logic             o_bus_grant_ok,   // High while master accesses may start.
  output logic             o_rx_suspended,   // Receive process held suspended or stopped.
  output logic             o_tx_suspended,   // Transmit process held suspended.
  output logic             o_txdesc_uf_we,   // Write underflow mark to descriptor.
  output logic [31:0]      o_txdesc_uf_data, // Descriptor word mask holding the mark.
  output logic             o_irq             // Level interrupt.
);
  masb_flag_if #(.W(32)) fl ();

  masb_flag_bank #(.W(32)) u_bank (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .fl        (fl)
  );

  masb_bus_e    bus_r,  bus_nxt;
  masb_rx_e     rx_r,   rx_nxt;
  logic         tx_susp_r, tx_susp_nxt;
  masb_bek_t    bek_r,  bek_nxt;
  logic [31:0]  irq_en_r, irq_en_nxt;
  logic         uf_we_r, uf_we_nxt;
  logic [31:0]  prdata_r, prdata_nxt;
  logic         wr_acc;
  logic         rd_acc;
  logic         mapped;
  logic         bus_fault;
  logic         abnormal;
  logic [31:0]  status_word;

  // Access phase decode; every access completes in its first access cycle.
  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & i_penable & ~i_pwrite;
  assign mapped = (i_paddr == `MASB_OFF_STATUS) || (i_paddr == `MASB_OFF_IRQ_EN) ||
                  (i_paddr == `MASB_OFF_IRQ_CLR) || (i_paddr == `MASB_OFF_EVENTS);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  assign bus_fault = i_parity_err | i_master_abort | i_target_abort;

  // Event set vector; only the in-scope and summary-source bits are wired.
  always_comb begin
    fl.set_vec = 32'h0;
    fl.set_vec[`MASB_BIT_BUSERR]   = bus_fault;                 // [R2]
    fl.set_vec[`MASB_BIT_GPT]      = i_gpt_expired;             // [R5]
    fl.set_vec[`MASB_BIT_RXWD]     = i_rxwd_expired;            // [R6]
    fl.set_vec[`MASB_BIT_RXSTOP]   = i_rx_to_stop;              // [R7]
    fl.set_vec[`MASB_BIT_RXNODESC] = i_rx_desc_miss;            // [R8]
    fl.set_vec[`MASB_BIT_RXDONE]   = i_rx_done;                 // [R11]
    fl.set_vec[`MASB_BIT_TXUF]     = i_tx_underflow;            // [R12]
    fl.set_vec[`MASB_BIT_TXJAB]    = i_tx_jabber;
    fl.set_vec[`MASB_BIT_TXSTOP]   = i_tx_stopped;
  end

  // Write-one-to-clear through the status offset or the clear register.
  // The transmit summary sources read zero but must still clear, or the
  // summary could never drop once a transmit event had been seen.
  always_comb begin
    fl.clr_vec = 32'h0;
    if (wr_acc && (i_paddr == `MASB_OFF_STATUS || i_paddr == `MASB_OFF_IRQ_CLR)) begin
      fl.clr_vec = i_pwdata & (`MASB_FLAG_MASK | `MASB_ABN_MASK); // [R14]
    end
  end

  // Summary is combinational so it falls as soon as its last source clears.
  assign abnormal = |(fl.flags & `MASB_ABN_MASK);               // [R1]

  // Reserved bits 14, 12, 10 and the unimplemented fields read zero.
  always_comb begin
    status_word = fl.flags & `MASB_FLAG_MASK;                   // [R16]
    status_word[`MASB_BIT_AIS] = abnormal;                      // [R16]
    status_word[`MASB_BEK_MSB:`MASB_BEK_LSB] = bek_r;
  end

  // Kind field keeps the first fault seen; it is only meaningful while bit 13 is set.
  always_comb begin
    bek_nxt = bek_r;
    if (bus_fault && !fl.flags[`MASB_BIT_BUSERR]) begin
      if (i_parity_err) begin
        bek_nxt = `MASB_BEK_PARITY;                             // [R15]
      end else if (i_master_abort) begin
        bek_nxt = `MASB_BEK_MABORT;                             // [R15]
      end else begin
        bek_nxt = `MASB_BEK_TABORT;                             // [R15]
      end
    end
  end

  // Bus halt: clearing the flag does not reopen the bus, so a stray clear
  // cannot resume mastering after a parity fault.
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      MASB_BUS_OK: begin
        if (bus_fault) begin
          bus_nxt = MASB_BUS_HALT;                              // [R3]
        end
      end
      MASB_BUS_HALT: begin
        if (i_soft_reset) begin
          bus_nxt = MASB_BUS_OK;                                // [R4]
        end
      end
      default: bus_nxt = MASB_BUS_OK;
    endcase
  end
  assign o_bus_grant_ok = (bus_r == MASB_BUS_OK) & ~bus_fault;  // [R3]

  // Receive process control as seen by this block.
  always_comb begin
    rx_nxt = rx_r;
    case (rx_r)
      MASB_RX_RUN: begin
        if (i_rx_to_stop) begin
          rx_nxt = MASB_RX_STOP;
        end else if (i_rx_desc_miss) begin
          rx_nxt = MASB_RX_SUSP;                                // [R8]
        end
      end
      MASB_RX_SUSP: begin
        if (i_rx_to_stop) begin
          rx_nxt = MASB_RX_STOP;
        end else if (i_rx_poll || i_rx_addr_match) begin
          rx_nxt = MASB_RX_RUN;                                 // [R9] [R10]
        end
      end
      MASB_RX_STOP: begin
        if (i_rx_poll) begin
          rx_nxt = MASB_RX_RUN;
        end
      end
      default: rx_nxt = MASB_RX_RUN;
    endcase
  end
  assign o_rx_suspended = (rx_r != MASB_RX_RUN);

  // Transmit suspend and the one-cycle descriptor write of the underflow mark.
  always_comb begin
    tx_susp_nxt = tx_susp_r;
    if (i_tx_underflow) begin
      tx_susp_nxt = 1'b1;                                       // [R13]
    end else if (i_tx_resume) begin
      tx_susp_nxt = 1'b0;
    end
    uf_we_nxt = i_tx_underflow;                                 // [R13]
  end
  assign o_tx_suspended  = tx_susp_r;
  assign o_txdesc_uf_data = 32'h1 << `MASB_TXDESC_UF_BIT;

  // Interrupt enable register, same layout as the status word.
  always_comb begin
    irq_en_nxt = irq_en_r;
    if (wr_acc && i_paddr == `MASB_OFF_IRQ_EN) begin
      irq_en_nxt = i_pwdata & `MASB_FLAG_MASK;
    end
  end
  assign o_irq = |(fl.flags & irq_en_r & `MASB_FLAG_MASK);

  // Read mux; data is registered so it is stable at the completing edge.
  always_comb begin
    prdata_nxt = prdata_r;
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        `MASB_OFF_STATUS: prdata_nxt = status_word;
        `MASB_OFF_IRQ_EN: prdata_nxt = irq_en_r;
        `MASB_OFF_EVENTS: prdata_nxt = {29'h0, tx_susp_r, o_rx_suspended, bus_r == MASB_BUS_HALT};
        default:          prdata_nxt = 32'h0;
      endcase
    end else if (rd_acc) begin
      prdata_nxt = prdata_r;
    end
  end
  assign o_prdata = prdata_r;

  // State registers only.
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_r     <= MASB_BUS_OK;
      rx_r      <= MASB_RX_RUN;
      tx_susp_r <= 1'b0;
      bek_r     <= `MASB_RESET_BEK;
      irq_en_r  <= 32'h0;
      uf_we_r   <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      bus_r     <= bus_nxt;
      rx_r      <= rx_nxt;
      tx_susp_r <= tx_susp_nxt;
      bek_r     <= bek_nxt;
      irq_en_r  <= irq_en_nxt;
      uf_we_r   <= uf_we_nxt;
      prdata_r  <= prdata_nxt;
    end
  end
  assign o_txdesc_uf_we = uf_we_r;
endmodule

// >>> verif/mac_abnormal_status_bits_tb.sv
/*
  Self-checking bench of the abnormal event status block over APB.
  Assumes the slave answers with pready and that reads of unmapped places give zero.
*/
`timescale 1ns/10ps
`include "masb_defines.svh"
module mac_abnormal_status_bits_tb;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, e;
  logic [14:0] ev;
  logic [64:0] note;
  logic [64:0] q[$];
  int          error_cnt, n_checks;
  int          bits[6] = '{11, 9, 8, 7, 6, 5};

  masb_status u_masb_status (
    .i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_soft_reset(ev[9]), .i_parity_err(ev[10]),
    .i_master_abort(ev[11]), .i_target_abort(ev[12]), .i_gpt_expired(ev[0]),
    .i_rxwd_expired(ev[1]), .i_rx_to_stop(ev[2]), .i_rx_desc_miss(ev[3]), .i_rx_poll(ev[6]),
    .i_rx_addr_match(ev[7]), .i_rx_done(ev[4]), .i_tx_underflow(ev[5]),
    .i_tx_stopped(ev[13]), .i_tx_jabber(ev[14]), .i_tx_resume(ev[8]), .o_bus_grant_ok(),
    .o_rx_suspended(), .o_tx_suspended(), .o_txdesc_uf_we(), .o_txdesc_uf_data(),
    .o_irq(irq));

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask

  task results;
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One APB transfer; an idle edge follows so the next setup never overlaps the release.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      results();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, m, input logic er);
    q.push_back({er, m, x});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic pulse(input logic [14:0] v);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask

  // Sampled at the next edge, before that edge's updates, so the bus stays edge aligned.
  task automatic irq_is(input logic v);
    @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, v});
  endtask

  // Read watcher: each completed read is compared with the oldest note.
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      chk("prdata", prdata & note[63:32], note[31:0]);
      chk("pslverr", {31'h0, pslverr}, {31'h0, note[64]});
    end
  end

  // Hang guard, well above the length of the sequence.
  initial begin
    #1000000;
    error_cnt++;
    results();
  end

  // Main sequence.
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(24));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`MASB_OFF_STATUS, 32'h0, '1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      e = (32'h1 << bits[i]) | ((bits[i] != 6) ? 32'h8000 : 32'h0);
      pulse(15'h1 << i);
      rd(`MASB_OFF_STATUS, e, '1, 1'b0);
      wr(`MASB_OFF_STATUS, $urandom & ~(32'h1 << bits[i]));
      rd(`MASB_OFF_STATUS, e, '1, 1'b0);
      wr(`MASB_OFF_STATUS, 32'h1 << bits[i]);
      rd(`MASB_OFF_STATUS, 32'h0, '1, 1'b0);
    end
    rd(`MASB_OFF_EVENTS, 32'h6, '1, 1'b0);
    pulse(15'h0140);
    wr(`MASB_OFF_EVENTS, '1);
    rd(`MASB_OFF_EVENTS, 32'h0, '1, 1'b0);
    pulse(15'h0008);
    rd(`MASB_OFF_EVENTS, 32'h2, '1, 1'b0);
    pulse(15'h0080);
    rd(`MASB_OFF_EVENTS, 32'h0, '1, 1'b0);
    wr(`MASB_OFF_IRQ_CLR, 32'h80);
    // Each fault kind in turn: kind code, summary, halt and reopen.
    for (int k = 0; k < 3; k++) begin
      pulse(15'h1 << (10 + k));
      rd(`MASB_OFF_STATUS, 32'ha000 | (32'(k) << 23), '1, 1'b0);
      rd(`MASB_OFF_EVENTS, 32'h1, '1, 1'b0);
      pulse(15'h0200);
      rd(`MASB_OFF_EVENTS, 32'h0, '1, 1'b0);
      wr(`MASB_OFF_IRQ_CLR, 32'h2000);
      rd(`MASB_OFF_STATUS, 32'h0, 32'hffff, 1'b0);
    end
    r = $urandom;
    wr(`MASB_OFF_IRQ_EN, r);
    rd(`MASB_OFF_IRQ_EN, r & 32'h2be0, '1, 1'b0);
    wr(`MASB_OFF_IRQ_EN, 32'h40);
    pulse(15'h0010);
    irq_is(1'b1);
    wr(`MASB_OFF_IRQ_EN, 32'h0);
    irq_is(1'b0);
    wr(`MASB_OFF_IRQ_EN, 32'h40);
    irq_is(1'b1);
    wr(`MASB_OFF_IRQ_CLR, 32'h40);
    irq_is(1'b0);
    rd(12'h100, 32'h0, '1, 1'b1);
    pulse(15'h6000);
    rd(`MASB_OFF_STATUS, 32'h8000, 32'hffff, 1'b0);
    wr(`MASB_OFF_STATUS, 32'ha);
    rd(`MASB_OFF_STATUS, 32'h0, 32'hffff, 1'b0);
    // Two faults at once record the higher priority kind; a reset then clears all state.
    pulse(15'h1800);
    rd(`MASB_OFF_STATUS, 32'h0080_a000, '1, 1'b0);
    rd(`MASB_OFF_EVENTS, 32'h1, '1, 1'b0);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`MASB_OFF_EVENTS, 32'h0, '1, 1'b0);
    rd(`MASB_OFF_STATUS, 32'h0, '1, 1'b0);
    results();
  end
endmodule

// >>> verif/masb_status_monitor.sv
/*
  Checker of the abnormal event status block, watching only its top ports.
  Assumes one clock domain and the active low asynchronous reset.
*/
`timescale 1ns/10ps
module masb_status_monitor (
  input wire logic        i_sys_clk,        // Clock.
  input wire logic        i_resetn,         // Reset.
  input wire logic        i_psel,           // Select.
  input wire logic        i_penable,        // Access.
  input wire logic        i_pwrite,         // Write.
  input wire logic [11:0] i_paddr,          // Address.
  input wire logic [31:0] o_prdata,         // Read data.
  input wire logic        i_soft_reset,     // Soft reset.
  input wire logic        i_parity_err,     // Fault.
  input wire logic        i_master_abort,   // Fault.
  input wire logic        i_target_abort,   // Fault.
  input wire logic        i_rx_to_stop,     // Rx stop.
  input wire logic        i_rx_desc_miss,   // Rx miss.
  input wire logic        i_rx_poll,        // Rx poll.
  input wire logic        i_rx_addr_match,  // Rx frame.
  input wire logic        i_tx_underflow,   // Tx underflow.
  input wire logic        o_bus_grant_ok,   // Grant.
  input wire logic        o_rx_suspended,   // Rx held.
  input wire logic        o_tx_suspended,   // Tx held.
  input wire logic        o_txdesc_uf_we,   // Mark strobe.
  input wire logic [31:0] o_txdesc_uf_data  // Mark word.
);
  // All properties share the system clock and are quiet during reset.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // A fault must close the bus in its own cycle, before any new access can start.
  a_fault_closes_bus: assert property ((i_parity_err | i_master_abort | i_target_abort)
    |-> !o_bus_grant_ok) else $error("bus open during fault");
  a_halt_holds: assert property (!o_bus_grant_ok && !i_soft_reset |=> !o_bus_grant_ok)
    else $error("bus reopened without soft reset");
  a_reopen_cause: assert property ($rose(o_bus_grant_ok) |-> $past(i_soft_reset))
    else $error("bus reopened without cause");
  // A soft reset with no new fault must reopen the bus on the next cycle.
  a_soft_reopen: assert property (!o_bus_grant_ok && i_soft_reset
    && !(i_parity_err | i_master_abort | i_target_abort)
    |=> o_bus_grant_ok || i_parity_err || i_master_abort || i_target_abort)
    else $error("soft reset did not reopen bus");
  a_rx_miss_suspend: assert property (i_rx_desc_miss && !i_rx_poll && !i_rx_addr_match
    |=> o_rx_suspended) else $error("receive not suspended");
  a_rx_stop_held: assert property (i_rx_to_stop |=> o_rx_suspended)
    else $error("receive not stopped");
  a_rx_poll_run: assert property (i_rx_poll && !i_rx_desc_miss && !i_rx_to_stop
    |=> !o_rx_suspended) else $error("poll did not resume receive");
  a_tx_uf_mark: assert property (i_tx_underflow |=> o_tx_suspended && o_txdesc_uf_we
    && o_txdesc_uf_data == 32'h0000_0002) else $error("underflow not handled");
  a_mark_cause: assert property (o_txdesc_uf_we |-> $past(i_tx_underflow))
    else $error("descriptor mark without underflow");
  a_reserved_zero: assert property (i_psel && i_penable && !i_pwrite && i_paddr == 12'h028
    |-> o_prdata[14] == 1'b0 && o_prdata[12] == 1'b0 && o_prdata[10] == 1'b0)
    else $error("reserved status bit set");
endmodule

bind masb_status masb_status_monitor u_masb_status_monitor (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .i_soft_reset(i_soft_reset),
  .i_parity_err(i_parity_err), .i_master_abort(i_master_abort),
  .i_target_abort(i_target_abort), .i_rx_to_stop(i_rx_to_stop),
  .i_rx_desc_miss(i_rx_desc_miss), .i_rx_poll(i_rx_poll), .i_rx_addr_match(i_rx_addr_match),
  .i_tx_underflow(i_tx_underflow), .o_bus_grant_ok(o_bus_grant_ok),
  .o_rx_suspended(o_rx_suspended), .o_tx_suspended(o_tx_suspended),
  .o_txdesc_uf_we(o_txdesc_uf_we), .o_txdesc_uf_data(o_txdesc_uf_data));
